// ---- logic/csb_pkg.sv ----
/*
 * Shared constants and types of the control switch and user button block:
 * register offsets, field positions, reset values, access levels, LED colours
 * and the event record.
 * Assumes a 32-bit AHB-Lite register bus decoded on the low byte of haddr.
 */
package csb_pkg;

	// ---------------------------------------------------------------
	// Sizes
	// ---------------------------------------------------------------
	localparam int NUM_SW = 5;
	localparam int NUM_BTN = 12;
	localparam int MAX_SW = 8;
	localparam int STAMP_W = 32;
	localparam int ADDR_W = 8;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_CMD = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_SWSTATE = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_CFG = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_ACCESS = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_BTNMODE = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_BTNSTAT = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_LEDSRC = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_LEDCOL = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_IRQSTAT = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_IRQMASK = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_LOGIN = 8'h28;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int CMD_ACT_LSB = 0;
	localparam int CMD_DEACT_LSB = 8;
	localparam int CMD_REMOTE_BIT = 16;
	localparam int CFG_SWLVL_LSB = 0;
	localparam int CFG_BTNLVL_LSB = 2;
	localparam int CFG_LR_BIT = 4;
	localparam int CFG_EVON_BIT = 5;
	localparam int CFG_EVOFF_BIT = 6;
	localparam int CFG_W = 7;
	localparam int IRQ_ON_LSB = 0;
	localparam int IRQ_OFF_LSB = 8;
	localparam int IRQ_W = 16;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [CFG_W-1:0] CFG_RESET = 7'h66;
	localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

	typedef enum logic [1:0] {
		ACC_USER = 2'h0,
		ACC_OPERATOR = 2'h1,
		ACC_CONFIG = 2'h2,
		ACC_SUPER = 2'h3
	} csb_access_t;

	typedef enum logic [1:0] {
		COL_RED = 2'h0,
		COL_ORANGE = 2'h1,
		COL_GREEN = 2'h2,
		COL_DARK = 2'h3
	} csb_color_t;

	typedef struct packed {
		logic [MAX_SW-1:0] on;
		logic [MAX_SW-1:0] off;
		logic [STAMP_W-1:0] stamp;
	} csb_event_t;

endpackage

// ---- logic/csb_user_button.sv ----
/*
 * One front-panel user button: pin synchroniser, press edge detector and
 * momentary or toggle status with complementary outputs.
 * Assumes the pin is asynchronous and the gate and mode come from ref_clk logic.
 */
`timescale 1ns/10ps
module csb_user_button (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic pinPressed,
	input wire logic allow,
	input wire logic toggleMode,
	output logic statusOn,
	output logic statusOff
);

	logic meta_r;
	logic sync_r;
	logic prev_r;
	logic rise;
	logic status_nxt;

	// ---------------------------------------------------------------
	// Synchroniser and edge
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			meta_r <= 1'h0;
			sync_r <= 1'h0;
			prev_r <= 1'h0;
		end
		else
		begin
			meta_r <= pinPressed;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign rise = sync_r & ~prev_r;

	// ---------------------------------------------------------------
	// Status
	// ---------------------------------------------------------------
	always_comb
	begin
		if (toggleMode)
			status_nxt = statusOn ^ (rise & allow);
		else
			status_nxt = sync_r & allow;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			statusOn <= 1'h0;
			statusOff <= 1'h1;
		end
		else
		begin
			statusOn <= status_nxt;
			statusOff <= ~status_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	sequence s_press;
		!sync_r ##1 sync_r;
	endsequence

	a_toggle_flip: assert property ((s_press ##0 (toggleMode && allow)) |=> statusOn != $past(statusOn))
		else $error("Toggle press did not flip status");
	a_toggle_single: assert property ((toggleMode && !(sync_r && !prev_r)) |=> $stable(statusOn))
		else $error("Toggle status changed without a new press");
	a_moment_follow: assert property (!toggleMode |=> statusOn == ($past(sync_r) && $past(allow)))
		else $error("Momentary status does not follow held button");
	a_on_off_pair: assert property (statusOn != statusOff)
		else $error("On and off outputs not complementary");

endmodule

// ---- logic/csb_control_buttons.sv ----
/*
 * Latching control switches and front-panel user buttons with LED drive,
 * event output, sticky interrupt status and an AHB-Lite register slave.
 * Assumes one 125 MHz clock, asynchronous active-high reset applied at power
 * up only, cpuReboot and ledAltSig from ref_clk logic, pins asynchronous.
 */
// Implementation choices: the address map and the AHB-Lite register port.
`timescale 1ns/10ps

module csb_control_buttons #(
	parameter int NUM_SW = csb_pkg::NUM_SW,
	parameter int NUM_BTN = csb_pkg::NUM_BTN
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic cpuReboot,
	input wire logic localModePin,
	input wire logic [NUM_BTN-1:0] btnPins,
	input wire logic [NUM_BTN-1:0] ledAltSig,
	output logic [NUM_SW-1:0] switchOut,
	output logic [NUM_SW-1:0] logicalOut,
	output logic [NUM_BTN-1:0] btnOn,
	output logic [NUM_BTN-1:0] btnOff,
	output logic [NUM_BTN-1:0] ledRed,
	output logic [NUM_BTN-1:0] ledOrange,
	output logic [NUM_BTN-1:0] ledGreen,
	output csb_pkg::csb_event_t evBus,
	output logic irq
);

	logic wrPend_r;
	logic [csb_pkg::ADDR_W-1:0] addr_r;
	logic [31:0] hrdata_r;
	logic [31:0] rdMux;
	logic [csb_pkg::CFG_W-1:0] cfg_r;
	csb_pkg::csb_access_t accessLvl_r;
	csb_pkg::csb_access_t swLvl;
	csb_pkg::csb_access_t btnLvl;
	logic [NUM_BTN-1:0] btnMode_r;
	logic [NUM_BTN-1:0] ledSrc_r;
	logic [2*NUM_BTN-1:0] ledCol_r;
	logic [csb_pkg::IRQ_W-1:0] irqStat_r;
	logic [csb_pkg::IRQ_W-1:0] irqMask_r;
	logic [csb_pkg::IRQ_W-1:0] irqSet;
	logic [csb_pkg::IRQ_W-1:0] irqClr;
	logic [NUM_SW-1:0] swState_r;
	logic [NUM_SW-1:0] logicalIn_r;
	logic [NUM_SW-1:0] actReq;
	logic [NUM_SW-1:0] deactReq;
	logic [NUM_SW-1:0] actEff;
	logic [NUM_SW-1:0] deactEff;
	logic [csb_pkg::STAMP_W-1:0] stamp_r;
	csb_pkg::csb_event_t evBus_r;
	logic cmdWr;
	logic cmdRemote;
	logic levelOk;
	logic localMeta_r;
	logic localSync_r;
	logic btnAllow;

	// ---------------------------------------------------------------
	// AHB-Lite slave
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			wrPend_r <= 1'h0;
			addr_r <= '0;
		end
		else if (hsel && htrans[1] && hready)
		begin
			wrPend_r <= hwrite;
			addr_r <= haddr[csb_pkg::ADDR_W-1:0];
		end
		else
			wrPend_r <= 1'h0;
	end

	// Read data captured in the address phase, zero wait states
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			hrdata_r <= csb_pkg::RDATA_ZERO;
		else if (hsel && htrans[1] && hready && !hwrite)
			hrdata_r <= rdMux;
	end

	assign hreadyout = 1'h1;
	assign hresp = 1'h0;
	assign hrdata = hrdata_r;

	always_comb
	begin
		rdMux = csb_pkg::RDATA_ZERO;
		unique case (haddr[csb_pkg::ADDR_W-1:0])
			csb_pkg::OFS_SWSTATE: rdMux[NUM_SW-1:0] = swState_r;
			csb_pkg::OFS_CFG: rdMux[csb_pkg::CFG_W-1:0] = cfg_r;
			csb_pkg::OFS_ACCESS: rdMux[1:0] = accessLvl_r;
			csb_pkg::OFS_BTNMODE: rdMux[NUM_BTN-1:0] = btnMode_r;
			csb_pkg::OFS_BTNSTAT: rdMux[NUM_BTN-1:0] = btnOn;
			csb_pkg::OFS_LEDSRC: rdMux[NUM_BTN-1:0] = ledSrc_r;
			csb_pkg::OFS_LEDCOL: rdMux[2*NUM_BTN-1:0] = ledCol_r;
			csb_pkg::OFS_IRQSTAT: rdMux[csb_pkg::IRQ_W-1:0] = irqStat_r;
			csb_pkg::OFS_IRQMASK: rdMux[csb_pkg::IRQ_W-1:0] = irqMask_r;
			csb_pkg::OFS_LOGIN: rdMux[NUM_SW-1:0] = logicalIn_r;
			default: rdMux = csb_pkg::RDATA_ZERO;
		endcase
	end

	// ---------------------------------------------------------------
	// Configuration registers
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			cfg_r <= csb_pkg::CFG_RESET;
		else if (wrPend_r && addr_r == csb_pkg::OFS_CFG)
			cfg_r <= hwdata[csb_pkg::CFG_W-1:0];
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			accessLvl_r <= csb_pkg::ACC_USER;
		else if (wrPend_r && addr_r == csb_pkg::OFS_ACCESS)
			accessLvl_r <= csb_pkg::csb_access_t'(hwdata[1:0]);
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			btnMode_r <= '0;
			ledSrc_r <= '0;
			ledCol_r <= '0;
		end
		else if (wrPend_r)
		begin
			if (addr_r == csb_pkg::OFS_BTNMODE)
				btnMode_r <= hwdata[NUM_BTN-1:0];
			if (addr_r == csb_pkg::OFS_LEDSRC)
				ledSrc_r <= hwdata[NUM_BTN-1:0];
			if (addr_r == csb_pkg::OFS_LEDCOL)
				ledCol_r <= hwdata[2*NUM_BTN-1:0];
		end
	end

	assign swLvl = csb_pkg::csb_access_t'(cfg_r[csb_pkg::CFG_SWLVL_LSB +: 2]);
	assign btnLvl = csb_pkg::csb_access_t'(cfg_r[csb_pkg::CFG_BTNLVL_LSB +: 2]);

	// ---------------------------------------------------------------
	// Control switches
	// ---------------------------------------------------------------
	assign cmdWr = wrPend_r && addr_r == csb_pkg::OFS_CMD;
	assign cmdRemote = hwdata[csb_pkg::CMD_REMOTE_BIT];
	assign actReq = hwdata[csb_pkg::CMD_ACT_LSB +: NUM_SW];
	assign deactReq = hwdata[csb_pkg::CMD_DEACT_LSB +: NUM_SW];
	assign levelOk = cmdRemote || (accessLvl_r >= swLvl);

	// Conflicting requests on one switch are dropped
	always_comb
	begin
		actEff = '0;
		deactEff = '0;
		if (cmdWr && levelOk)
		begin
			actEff = actReq & ~deactReq & ~swState_r;
			deactEff = deactReq & ~actReq & swState_r;
		end
	end

	// Cleared only by power-on reset, reboot leaves it alone
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			swState_r <= '0;
		else
			swState_r <= (swState_r | actEff) & ~deactEff;
	end

	assign switchOut = swState_r;

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			logicalIn_r <= '0;
		else if (cpuReboot)
			logicalIn_r <= '0;
		else if (wrPend_r && addr_r == csb_pkg::OFS_LOGIN)
			logicalIn_r <= hwdata[NUM_SW-1:0];
	end

	assign logicalOut = logicalIn_r;

	// ---------------------------------------------------------------
	// Events and time stamp
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			stamp_r <= '0;
		else
			stamp_r <= stamp_r + 1'h1;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			evBus_r <= '0;
		else
		begin
			evBus_r.on <= '0;
			evBus_r.off <= '0;
			evBus_r.on[NUM_SW-1:0] <= actEff & {NUM_SW{cfg_r[csb_pkg::CFG_EVON_BIT]}};
			evBus_r.off[NUM_SW-1:0] <= deactEff & {NUM_SW{cfg_r[csb_pkg::CFG_EVOFF_BIT]}};
			if ((actEff | deactEff) != '0)
				evBus_r.stamp <= stamp_r;
		end
	end

	assign evBus = evBus_r;

	// ---------------------------------------------------------------
	// Interrupt status and mask
	// ---------------------------------------------------------------
	always_comb
	begin
		irqSet = '0;
		irqSet[csb_pkg::IRQ_ON_LSB +: NUM_SW] = actEff;
		irqSet[csb_pkg::IRQ_OFF_LSB +: NUM_SW] = deactEff;
		irqClr = '0;
		if (wrPend_r && addr_r == csb_pkg::OFS_IRQSTAT)
			irqClr = hwdata[csb_pkg::IRQ_W-1:0];
	end

	// New event wins over a clear in the same cycle
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			irqStat_r <= '0;
		else
			irqStat_r <= (irqStat_r & ~irqClr) | irqSet;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			irqMask_r <= '0;
		else if (wrPend_r && addr_r == csb_pkg::OFS_IRQMASK)
			irqMask_r <= hwdata[csb_pkg::IRQ_W-1:0];
	end

	assign irq = |(irqStat_r & irqMask_r);

	// ---------------------------------------------------------------
	// User buttons
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			localMeta_r <= 1'h0;
			localSync_r <= 1'h0;
		end
		else
		begin
			localMeta_r <= localModePin;
			localSync_r <= localMeta_r;
		end
	end

	assign btnAllow = (accessLvl_r >= btnLvl)
		&& (!cfg_r[csb_pkg::CFG_LR_BIT] || localSync_r);

	generate
		for (genvar i = 0; i < NUM_BTN; i++)
		begin : gBtn
			// Status driven by the front-panel pin only
			csb_user_button uBtn (
				.ref_clk(ref_clk),
				.rst(rst),
				.pinPressed(btnPins[i]),
				.allow(btnAllow),
				.toggleMode(btnMode_r[i]),
				.statusOn(btnOn[i]),
				.statusOff(btnOff[i])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// LED drive
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			ledRed <= '0;
			ledOrange <= '0;
			ledGreen <= '0;
		end
		else
		begin
			for (int i = 0; i < NUM_BTN; i++)
			begin
				ledRed[i] <= (ledSrc_r[i] ? ledAltSig[i] : btnOn[i])
					&& ledCol_r[2*i +: 2] == csb_pkg::COL_RED;
				ledOrange[i] <= (ledSrc_r[i] ? ledAltSig[i] : btnOn[i])
					&& ledCol_r[2*i +: 2] == csb_pkg::COL_ORANGE;
				ledGreen[i] <= (ledSrc_r[i] ? ledAltSig[i] : btnOn[i])
					&& ledCol_r[2*i +: 2] == csb_pkg::COL_GREEN;
			end
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	sequence s_cmd_on;
		cmdWr ##0 (actEff != '0);
	endsequence

	sequence s_cmd_off;
		cmdWr ##0 (deactEff != '0);
	endsequence

	a_cmd_latch: assert property (s_cmd_on |=> (swState_r & $past(actEff)) == $past(actEff))
		else $error("Switch did not latch on");
	a_cmd_release: assert property (s_cmd_off |=> (swState_r & $past(deactEff)) == '0)
		else $error("Switch did not latch off");
	a_no_aux_path: assert property (!cmdWr |=> $stable(swState_r))
		else $error("Switch changed without a command");
	a_local_gate: assert property ((cmdWr && !cmdRemote && accessLvl_r < swLvl) |=> $stable(swState_r))
		else $error("Local command taken below access level");
	a_reboot_keep: assert property ((cpuReboot && !cmdWr) |=> $stable(swState_r) && logicalIn_r == '0)
		else $error("Reboot handling of switch or logical input wrong");
	a_event_on: assert property ((s_cmd_on ##0 cfg_r[csb_pkg::CFG_EVON_BIT])
		|=> evBus_r.on[NUM_SW-1:0] == $past(actEff) && evBus_r.stamp == $past(stamp_r))
		else $error("ON event missing or stamp wrong");
	a_event_filter: assert property (!cfg_r[csb_pkg::CFG_EVOFF_BIT] |=> evBus_r.off == '0)
		else $error("Unselected OFF event stored");
	a_same_state: assert property ((cmdWr && (actReq & ~swState_r) == '0 && (deactReq & swState_r) == '0)
		|=> $stable(swState_r) && evBus_r.on == '0 && evBus_r.off == '0)
		else $error("Command for held state had an effect");
	a_irq_sticky: assert property ((irqSet != '0) |=> (irqStat_r & $past(irqSet)) == $past(irqSet))
		else $error("Event lost against a clear");

endmodule

// ---- dv/csb_panel_model.sv ----
/*
 * Behavioural front panel: user button contacts and the local/remote selector.
 * Assumes the bench states, at ref_clk edges, which buttons the operator holds.
 */
`timescale 1ns/10ps
module csb_panel_model (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [csb_pkg::NUM_BTN-1:0] pressReq,
	input wire logic localReq,
	output logic [csb_pkg::NUM_BTN-1:0] btnPins,
	output logic localModePin
);
	// ---------------------------------------------------------------
	// Contacts
	// ---------------------------------------------------------------
	// Contacts close one cycle after the operator acts; open ones read low
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			btnPins <= '0;
			localModePin <= 1'b0;
		end
		else
		begin
			btnPins <= pressReq;
			localModePin <= localReq;
		end
	end
endmodule

// ---- dv/csb_control_buttons_tb.sv ----
/*
 * Self-checking bench of the control switch and user button block.
 * Assumes the AHB-Lite slave answers with zero wait states and the panel model.
 */
`timescale 1ns/10ps
module csb_control_buttons_tb;
	logic ref_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, cpuReboot = 1'b0;
	logic localReq = 1'b0, clrEv = 1'b0, hresp, irq, hreadyout, localModePin;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [11:0] pressReq = 12'h000, ledAltSig = 12'h000, btnPins;
	logic [11:0] btnOn, btnOff, ledRed, ledOrange, ledGreen;
	logic [4:0] switchOut, logicalOut, seenOn, seenOff;
	csb_pkg::csb_event_t evBus;
	int fails = 0, compares = 0, cyc = 0;
	logic [31:0] stampSeen, stampExp;

	initial
	forever
		#4 ref_clk = ~ref_clk;

	csb_panel_model panel_u (.ref_clk(ref_clk), .rst(rst), .pressReq(pressReq), .localReq(localReq),
		.btnPins(btnPins), .localModePin(localModePin));

	csb_control_buttons dut_u (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .cpuReboot(cpuReboot), .localModePin(localModePin),
		.btnPins(btnPins), .ledAltSig(ledAltSig), .switchOut(switchOut), .logicalOut(logicalOut),
		.btnOn(btnOn), .btnOff(btnOff), .ledRed(ledRed), .ledOrange(ledOrange), .ledGreen(ledGreen),
		.evBus(evBus), .irq(irq));

	// ---------------------------------------------------------------
	// Event pulse collector
	// ---------------------------------------------------------------
	always @(posedge ref_clk)
	begin
		if (clrEv)
		begin
			seenOn <= 5'h00;
			seenOff <= 5'h00;
		end
		else
		begin
			seenOn <= seenOn | evBus.on[4:0];
			seenOff <= seenOff | evBus.off[4:0];
		end
	end

	// Own cycle count; an ON pulse carries the count of the edge that took the command
	always @(posedge ref_clk)
	begin
		cyc <= rst ? 0 : cyc + 1;
		if (evBus.on != 8'h00)
		begin
			stampSeen <= evBus.stamp;
			stampExp <= 32'(cyc - 1);
		end
	end

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task give_verdict;
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Bounded wait for hready at the next edges
	task waitReady;
		int n;
		n = 0;
		@(posedge ref_clk);
		while (hreadyout !== 1'b1 && n < 100)
		begin
			n++;
			@(posedge ref_clk);
		end
		if (n >= 100)
		begin
			fails++;
			give_verdict();
		end
	endtask

	task busWrite(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		hsel <= 1'b1;
		haddr <= 32'(a);
		htrans <= 2'h2;
		hwrite <= 1'b1;
		waitReady();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		waitReady();
		@(negedge ref_clk);
	endtask

	task rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		hsel <= 1'b1;
		haddr <= 32'(a);
		htrans <= 2'h2;
		hwrite <= 1'b0;
		waitReady();
		hsel <= 1'b0;
		htrans <= 2'h0;
		waitReady();
		rd = hrdata;
		check(what, rd, exp);
	endtask

	task clearEv;
		@(posedge ref_clk);
		clrEv <= 1'b1;
		@(posedge ref_clk);
		clrEv <= 1'b0;
	endtask

	// Operator acts on one button, then time for sync, status and LED
	task setPin(input int i, input logic v);
		@(posedge ref_clk);
		pressReq[i] <= v;
		repeat (8) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial
	begin
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		@(negedge ref_clk);
		check("switchOut reset", 32'(switchOut), 32'h0000_0000);
		check("btnOff reset", 32'(btnOff), 32'h0000_0FFF);
		check("hresp okay", 32'(hresp), 32'h0000_0000);
		rdChk("cfg reset", csb_pkg::OFS_CFG, 32'h0000_0066);
		rdChk("access reset", csb_pkg::OFS_ACCESS, 32'h0000_0000);
		rdChk("unmapped", 8'h3C, 32'h0000_0000);
		busWrite(csb_pkg::OFS_IRQMASK, 32'h0000_1F1F);
		clearEv();
		busWrite(csb_pkg::OFS_CMD, 32'h0001_0011);
		check("switchOut act", 32'(switchOut), 32'h0000_0011);
		@(negedge ref_clk);
		check("on events", 32'(seenOn), 32'h0000_0011);
		check("event stamp", stampSeen, stampExp);
		check("irq set", 32'(irq), 32'h0000_0001);
		rdChk("irqstat on", csb_pkg::OFS_IRQSTAT, 32'h0000_0011);
		rdChk("swstate", csb_pkg::OFS_SWSTATE, 32'h0000_0011);
		busWrite(csb_pkg::OFS_IRQSTAT, 32'h0000_0011);
		rdChk("irqstat clear", csb_pkg::OFS_IRQSTAT, 32'h0000_0000);
		check("irq clear", 32'(irq), 32'h0000_0000);
		clearEv();
		busWrite(csb_pkg::OFS_CMD, 32'h0001_0001);
		@(negedge ref_clk);
		check("held no event", 32'(seenOn), 32'h0000_0000);
		rdChk("held no status", csb_pkg::OFS_IRQSTAT, 32'h0000_0000);
		busWrite(csb_pkg::OFS_CMD, 32'h0000_1000);
		check("local refused user", 32'(switchOut), 32'h0000_0011);
		busWrite(csb_pkg::OFS_ACCESS, 32'h0000_0001);
		busWrite(csb_pkg::OFS_CMD, 32'h0000_1000);
		check("local refused operator", 32'(switchOut), 32'h0000_0011);
		busWrite(csb_pkg::OFS_ACCESS, 32'h0000_0002);
		busWrite(csb_pkg::OFS_CMD, 32'h0000_1000);
		check("local deact", 32'(switchOut), 32'h0000_0001);
		@(negedge ref_clk);
		check("off event", 32'(seenOff), 32'h0000_0010);
		busWrite(csb_pkg::OFS_CFG, 32'h0000_0046);
		clearEv();
		busWrite(csb_pkg::OFS_CMD, 32'h0001_0010);
		@(negedge ref_clk);
		check("on not stored", 32'(seenOn), 32'h0000_0000);
		rdChk("irqstat both", csb_pkg::OFS_IRQSTAT, 32'h0000_1010);
		busWrite(csb_pkg::OFS_CFG, 32'h0000_0026);
		clearEv();
		busWrite(csb_pkg::OFS_CMD, 32'h0001_0100);
		check("remote deact", 32'(switchOut), 32'h0000_0010);
		@(negedge ref_clk);
		check("off not stored", 32'(seenOff), 32'h0000_0000);
		busWrite(csb_pkg::OFS_CMD, 32'h0001_0001);
		check("remote react", 32'(switchOut), 32'h0000_0011);
		busWrite(csb_pkg::OFS_CFG, 32'h0000_0066);
		busWrite(csb_pkg::OFS_LOGIN, 32'h0000_0015);
		check("logical set", 32'(logicalOut), 32'h0000_0015);
		@(posedge ref_clk);
		cpuReboot <= 1'b1;
		@(posedge ref_clk);
		cpuReboot <= 1'b0;
		repeat (2) @(negedge ref_clk);
		check("logical reboot", 32'(logicalOut), 32'h0000_0000);
		check("switch reboot", 32'(switchOut), 32'h0000_0011);
		setPin(3, 1'b1);
		check("momentary held", 32'(btnOn), 32'h0000_0008);
		check("off complement", 32'(btnOff), 32'h0000_0FF7);
		setPin(3, 1'b0);
		check("momentary release", 32'(btnOn), 32'h0000_0000);
		busWrite(csb_pkg::OFS_ACCESS, 32'h0000_0000);
		setPin(3, 1'b1);
		check("press low access", 32'(btnOn), 32'h0000_0000);
		setPin(3, 1'b0);
		busWrite(csb_pkg::OFS_ACCESS, 32'h0000_0002);
		busWrite(csb_pkg::OFS_BTNMODE, 32'h0000_0008);
		setPin(3, 1'b1);
		setPin(3, 1'b0);
		check("toggle first", 32'(btnOn), 32'h0000_0008);
		rdChk("btnstat", csb_pkg::OFS_BTNSTAT, 32'h0000_0008);
		setPin(3, 1'b1);
		check("toggle second", 32'(btnOn), 32'h0000_0000);
		setPin(3, 1'b0);
		busWrite(csb_pkg::OFS_BTNMODE, 32'h0000_0000);
		busWrite(csb_pkg::OFS_CFG, 32'h0000_0076);
		setPin(5, 1'b1);
		check("remote selector", 32'(btnOn), 32'h0000_0000);
		setPin(5, 1'b0);
		@(posedge ref_clk);
		localReq <= 1'b1;
		setPin(5, 1'b1);
		check("local selector", 32'(btnOn), 32'h0000_0020);
		setPin(5, 1'b0);
		busWrite(csb_pkg::OFS_LEDCOL, 32'h0000_0006);
		busWrite(csb_pkg::OFS_LEDSRC, 32'h0000_0002);
		setPin(0, 1'b1);
		check("led green", 32'(ledGreen), 32'h0000_0001);
		@(posedge ref_clk);
		ledAltSig <= 12'h002;
		repeat (3) @(negedge ref_clk);
		check("led orange", 32'(ledOrange), 32'h0000_0002);
		check("led red", 32'(ledRed), 32'h0000_0000);
		check("switch untouched", 32'(switchOut), 32'h0000_0011);
		busWrite(csb_pkg::OFS_LEDCOL, 32'h0000_0004);
		@(negedge ref_clk);
		check("led red on", 32'(ledRed), 32'h0000_0001);
		check("led green off", 32'(ledGreen), 32'h0000_0000);
		busWrite(csb_pkg::OFS_LEDCOL, 32'h0000_000F);
		@(negedge ref_clk);
		check("led dark", 32'(ledOrange), 32'h0000_0000);
		busWrite(csb_pkg::OFS_CMD, 32'h0001_0000);
		check("remote no button", 32'(btnOn), 32'h0000_0001);
		give_verdict();
	end
endmodule
